// *** hdl/asr_pkg.sv ***
package asr_pkg;
    // chip select pattern that addresses the block
    localparam logic [2:0] CS_MATCH = 3'h6;
    // line_control field positions
    localparam int CR_RATIO_LSB = 0;
    localparam int CR_FMT_LSB = 2;
    localparam int CR_TXC_LSB = 5;
    localparam int CR_RIE_BIT = 7;
    localparam logic [7:0] CR_RESET = 8'h00;
    // line_status bit positions
    localparam int SR_RDRF = 0;
    localparam int SR_TDRE = 1;
    localparam int SR_DCD = 2;
    localparam int SR_CTS = 3;
    localparam int SR_FRAMING = 4;
    localparam int SR_OVR = 5;
    localparam int SR_PARITY = 6;
    localparam int SR_IRQ = 7;
    // bit timing in link clock edges
    localparam logic [6:0] FULL_16 = 7'h10;
    localparam logic [6:0] FULL_64 = 7'h40;
    localparam logic [6:0] HALF_16 = 7'h08;
    localparam logic [6:0] HALF_64 = 7'h20;
    // received word buffer: 8 data bits, framing and parity error
    localparam int RXQ_WIDTH = 10;
    localparam int RXQ_DEPTH = 4;

    typedef enum logic [1:0] {
        ASR_DIV1 = 2'h0,
        ASR_DIV16 = 2'h1,
        ASR_DIV64 = 2'h2,
        ASR_MRESET = 2'h3
    } asr_ratio_t;

    typedef enum logic [1:0] {
        ASR_TXC_RTS = 2'h0,
        ASR_TXC_RTS_IRQ = 2'h1,
        ASR_TXC_NORTS = 2'h2,
        ASR_TXC_BREAK = 2'h3
    } asr_txc_t;

    typedef enum logic [2:0] {
        ASR_IDLE = 3'h0,
        ASR_START = 3'h1,
        ASR_DATA = 3'h2,
        ASR_PAR = 3'h3,
        ASR_STOP = 3'h4
    } asr_state_t;
endpackage

// *** hdl/asr_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module asr_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = count != (AW+1)'(DEPTH);
    assign out_valid_out = count != '0;
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // asr_fifo

module asr_top (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic bus_e_in,
    input wire logic [2:0] cs_in,
    input wire logic rnw_in,
    input wire logic register_select_in,
    input wire logic [7:0] di_in,
    output logic [7:0] do_out,
    output logic irq_n_out,
    input wire logic rx_clk_in,
    input wire logic rx_data_in,
    input wire logic tx_clk_in,
    output logic tx_data_out,
    output logic rts_n_out,
    input wire logic cts_n_in,
    input wire logic dcd_n_in
);
    // every pin crosses two flops; a third stage only feeds edge detect
    logic [18:0] pin_q1;
    logic [18:0] pin_q2;
    logic [3:0] edge_q3;
    logic [2:0] sync_fill;
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_q1 <= '0;
            pin_q2 <= '0;
            edge_q3 <= '0;
            sync_fill <= '0;
        end else begin
            pin_q1 <= {bus_e_in, cs_in, rnw_in, register_select_in, di_in,
                       rx_clk_in, rx_data_in, tx_clk_in, cts_n_in, dcd_n_in};
            pin_q2 <= pin_q1;
            edge_q3 <= {pin_q2[18], pin_q2[4], pin_q2[2], pin_q2[0]};
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    logic e_s, rnw_s, register_select_s, rxc_s, rxd_s, txc_s, cts_n_s, dcd_n_s;
    logic [2:0] cs_s;
    logic [7:0] di_s;
    assign {e_s, cs_s, rnw_s, register_select_s, di_s, rxc_s, rxd_s, txc_s, cts_n_s, dcd_n_s} = pin_q2;
    // edges wait for a filled pipe: a pin already high at release is no fresh edge
    logic e_rise, e_fall, rx_rise, tx_rise, tx_fall, dcd_rise, sel;
    assign e_rise = e_s && !edge_q3[3] && sync_fill[2];
    assign e_fall = !e_s && edge_q3[3] && sync_fill[2];
    assign rx_rise = rxc_s && !edge_q3[2] && sync_fill[2];
    assign tx_rise = txc_s && !edge_q3[1] && sync_fill[2];
    assign tx_fall = !txc_s && edge_q3[1] && sync_fill[2];
    assign dcd_rise = dcd_n_s && !edge_q3[0] && sync_fill[2];
    assign sel = cs_s == asr_pkg::CS_MATCH;

    logic [7:0] line_control;
    logic [7:0] tx_holding_reg;
    logic [7:0] rx_holding_reg;
    logic ctrl_wr, thr_wr, sr_rd, rxh_rd;
    assign ctrl_wr = e_fall && sel && !rnw_s && !register_select_s;
    assign thr_wr = e_fall && sel && !rnw_s && register_select_s;
    assign sr_rd = e_rise && sel && rnw_s && !register_select_s;
    assign rxh_rd = e_rise && sel && rnw_s && register_select_s;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            line_control <= asr_pkg::CR_RESET;
        end else if (ctrl_wr) begin
            line_control <= di_s;
        end
    end

    logic [1:0] ratio;
    logic [2:0] fmt;
    logic [1:0] txc;
    logic rie, mr, len8, two_stop, par_en, par_odd;
    logic [6:0] bit_full, bit_half;
    assign ratio = line_control[asr_pkg::CR_RATIO_LSB +: 2];
    assign fmt = line_control[asr_pkg::CR_FMT_LSB +: 3];
    assign txc = line_control[asr_pkg::CR_TXC_LSB +: 2];
    assign rie = line_control[asr_pkg::CR_RIE_BIT];
    assign mr = ratio == asr_pkg::ASR_MRESET;
    assign len8 = fmt[2];
    assign two_stop = fmt[2:1] == 2'h0;
    assign par_en = fmt[2:1] != 2'h2;
    assign par_odd = fmt[0];
    // one timing pair serves both directions
    assign bit_full = (ratio == asr_pkg::ASR_DIV64) ? asr_pkg::FULL_64 :
                      (ratio == asr_pkg::ASR_DIV16) ? asr_pkg::FULL_16 : 7'h01;
    assign bit_half = (ratio == asr_pkg::ASR_DIV64) ? asr_pkg::HALF_64 : asr_pkg::HALF_16;

    // receiver
    asr_pkg::asr_state_t rx_state;
    logic [6:0] rx_cnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_par, rx_stop2, rx_store, rx_framing_err;
    logic q_in_ready, q_out_valid, q_pop;
    logic [9:0] q_out;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_state <= asr_pkg::ASR_IDLE;
            rx_cnt <= '0;
            rx_bits <= '0;
            rx_shift <= '0;
            rx_par <= 1'b0;
            rx_stop2 <= 1'b0;
            rx_store <= 1'b0;
            rx_framing_err <= 1'b0;
        end else begin
            rx_store <= 1'b0;
            if (mr) begin
                rx_state <= asr_pkg::ASR_IDLE;
                rx_cnt <= '0;
            end else if (rx_rise && rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 7'h01;
            end else if (rx_rise) begin
                rx_cnt <= bit_full - 7'h01;
                unique case (rx_state)
                    asr_pkg::ASR_IDLE: begin
                        if (!rxd_s && ratio == asr_pkg::ASR_DIV1) begin
                            rx_state <= asr_pkg::ASR_DATA;
                            rx_bits <= '0;
                            rx_par <= 1'b0;
                        end else if (!rxd_s) begin
                            rx_state <= asr_pkg::ASR_START;
                            rx_cnt <= bit_half - 7'h01;
                        end else begin
                            rx_cnt <= '0;
                        end
                    end
                    asr_pkg::ASR_START: begin
                        rx_state <= rxd_s ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DATA;
                        rx_bits <= '0;
                        rx_par <= 1'b0;
                    end
                    asr_pkg::ASR_DATA: begin
                        rx_shift <= {rxd_s, rx_shift[7:1]};
                        rx_par <= rx_par ^ rxd_s;
                        rx_bits <= rx_bits + 3'h1;
                        if (rx_bits == {2'h3, len8}) begin
                            rx_state <= par_en ? asr_pkg::ASR_PAR : asr_pkg::ASR_STOP;
                            rx_stop2 <= two_stop;
                        end
                    end
                    asr_pkg::ASR_PAR: begin
                        rx_par <= rx_par ^ rxd_s ^ par_odd;
                        rx_state <= asr_pkg::ASR_STOP;
                    end
                    asr_pkg::ASR_STOP: begin
                        rx_framing_err <= !rxd_s;
                        if (!rxd_s || !rx_stop2) begin
                            rx_state <= asr_pkg::ASR_IDLE;
                            rx_store <= 1'b1;
                            rx_cnt <= '0;
                        end
                        rx_stop2 <= 1'b0;
                    end
                    default: rx_state <= asr_pkg::ASR_IDLE;
                endcase
            end
        end
    end

    logic [7:0] rx_word;
    logic rx_parity_err;
    assign rx_word = len8 ? rx_shift : {1'b0, rx_shift[7:1]};
    assign rx_parity_err = par_en && rx_par;

    // a full buffer drops the incoming word: that is the overrun
    asr_fifo #(
        .WIDTH(asr_pkg::RXQ_WIDTH),
        .DEPTH(asr_pkg::RXQ_DEPTH)
    ) u_rxq (
        .clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .flush_in(mr),
        .in_valid_in(rx_store),
        .in_ready_out(q_in_ready),
        .in_data_in({rx_parity_err, rx_framing_err, rx_word}),
        .out_valid_out(q_out_valid),
        .out_ready_in(q_pop),
        .out_data_out(q_out)
    );

    logic rdrf, framing_err_flag, parity_err_flag, ovr, ovr_pend, dcd, dcd_armed, tdre, cts_hold;
    // no pop while the buffer is being flushed, or a word would vanish unseen
    assign q_pop = q_out_valid && !rdrf && !mr;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_holding_reg <= '0;
            rdrf <= 1'b0;
            framing_err_flag <= 1'b0;
            parity_err_flag <= 1'b0;
        end else if (mr) begin
            rdrf <= 1'b0;
            framing_err_flag <= 1'b0;
            parity_err_flag <= 1'b0;
        end else if (q_pop) begin
            rx_holding_reg <= q_out[7:0];
            rdrf <= 1'b1;
            framing_err_flag <= q_out[8];
            parity_err_flag <= q_out[9];
        end else if (rxh_rd) begin
            rdrf <= 1'b0;
            parity_err_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ovr <= 1'b0;
            ovr_pend <= 1'b0;
        end else if (mr) begin
            ovr <= 1'b0;
            ovr_pend <= 1'b0;
        end else begin
            if (rx_store && !q_in_ready) begin
                ovr_pend <= 1'b1;
            end else if (rxh_rd) begin
                ovr_pend <= 1'b0;
            end
            if (rxh_rd) begin
                ovr <= ovr_pend;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dcd <= 1'b0;
            dcd_armed <= 1'b0;
        end else if (mr) begin
            dcd <= 1'b0;
            dcd_armed <= 1'b0;
        end else begin
            if (dcd_rise) begin
                dcd <= 1'b1;
            end else if (sr_rd && dcd_armed) begin
                dcd <= 1'b0;
            end
            if (rxh_rd) begin
                dcd_armed <= 1'b1;
            end else if (sr_rd) begin
                dcd_armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cts_hold <= 1'b1;
        end else if (tx_rise) begin
            cts_hold <= 1'b0;
        end
    end

    // transmitter
    asr_pkg::asr_state_t tx_state;
    logic [6:0] tx_cnt;
    logic [2:0] tx_bits;
    logic [7:0] tx_shift;
    logic tx_par, tx_stop2, thr_full, tx_load, tx_line;
    assign tx_load = tx_fall && tx_state == asr_pkg::ASR_IDLE && thr_full && !mr;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_holding_reg <= '0;
            thr_full <= 1'b0;
            tdre <= 1'b0;
        end else if (mr) begin
            thr_full <= 1'b0;
            tdre <= 1'b0;
        end else if (thr_wr) begin
            tx_holding_reg <= di_s;
            thr_full <= 1'b1;
            tdre <= 1'b0;
        end else if (tx_load) begin
            thr_full <= 1'b0;
            tdre <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_state <= asr_pkg::ASR_IDLE;
            tx_cnt <= '0;
            tx_bits <= '0;
            tx_shift <= '0;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            tx_line <= 1'b1;
        end else if (mr) begin
            tx_state <= asr_pkg::ASR_IDLE;
            tx_cnt <= '0;
            tx_line <= 1'b1;
        end else if (tx_load) begin
            tx_state <= asr_pkg::ASR_START;
            tx_shift <= tx_holding_reg;
            tx_par <= par_odd;
            tx_bits <= '0;
            tx_stop2 <= two_stop;
            tx_cnt <= bit_full - 7'h01;
            tx_line <= 1'b0;
        end else if (tx_fall && tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 7'h01;
        end else if (tx_fall && tx_state != asr_pkg::ASR_IDLE) begin
            tx_cnt <= bit_full - 7'h01;
            unique case (tx_state)
                asr_pkg::ASR_START, asr_pkg::ASR_DATA: begin
                    if (tx_state == asr_pkg::ASR_DATA && tx_bits == {2'h3, len8}) begin
                        tx_state <= par_en ? asr_pkg::ASR_PAR : asr_pkg::ASR_STOP;
                        tx_line <= par_en ? tx_par : 1'b1;
                    end else begin
                        tx_state <= asr_pkg::ASR_DATA;
                        tx_line <= tx_shift[0];
                        tx_par <= tx_par ^ tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bits <= tx_bits + {2'h0, tx_state == asr_pkg::ASR_DATA};
                    end
                end
                asr_pkg::ASR_PAR: begin
                    tx_state <= asr_pkg::ASR_STOP;
                    tx_line <= 1'b1;
                end
                asr_pkg::ASR_STOP: begin
                    tx_stop2 <= 1'b0;
                    if (!tx_stop2) begin
                        tx_state <= asr_pkg::ASR_IDLE;
                        tx_cnt <= '0;
                    end
                end
                default: tx_state <= asr_pkg::ASR_IDLE;
            endcase
        end
    end

    // outputs
    logic cts_bit, tdre_bit, irq;
    assign cts_bit = cts_hold || cts_n_s;
    assign tdre_bit = tdre && !cts_n_s;
    assign irq = (rie && (rdrf || ovr || dcd)) ||
                 (txc == asr_pkg::ASR_TXC_RTS_IRQ && tdre && !cts_n_s);
    assign irq_n_out = !irq;
    assign rts_n_out = txc == asr_pkg::ASR_TXC_NORTS;
    assign tx_data_out = tx_line && txc != asr_pkg::ASR_TXC_BREAK;

    logic [7:0] status;
    always_comb begin
        status = '0;
        status[asr_pkg::SR_RDRF] = rdrf;
        status[asr_pkg::SR_TDRE] = tdre_bit;
        status[asr_pkg::SR_DCD] = dcd;
        status[asr_pkg::SR_CTS] = cts_bit;
        status[asr_pkg::SR_FRAMING] = framing_err_flag;
        status[asr_pkg::SR_OVR] = ovr;
        status[asr_pkg::SR_PARITY] = parity_err_flag;
        status[asr_pkg::SR_IRQ] = irq;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            do_out <= '0;
        end else if (sr_rd || rxh_rd) begin
            do_out <= register_select_s ? rx_holding_reg : status;
        end
    end

    a_irq_pin_bit: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sr_rd |=> do_out[asr_pkg::SR_IRQ] == $past(!irq_n_out))
        else $error("status irq bit not inverse of pin");
    a_rie_gate: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (!rie && txc != asr_pkg::ASR_TXC_RTS_IRQ) |-> irq_n_out)
        else $error("interrupt without enable");
    a_tdre_cts: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (sr_rd && cts_n_s && !cts_hold) |=> !do_out[asr_pkg::SR_TDRE])
        else $error("tdre shown while cts high");
    a_mreset_clear: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        mr |=> !rdrf && !tdre && !ovr && !framing_err_flag && !parity_err_flag && !dcd && tx_state == asr_pkg::ASR_IDLE)
        else $error("master reset did not clear state");
    a_rx_bit7_zero: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (q_pop && !len8) |=> !rx_holding_reg[7])
        else $error("seven bit word bit 7 set");
    a_tx_hold: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (thr_full && tx_state != asr_pkg::ASR_IDLE && !thr_wr) |=> thr_full || mr)
        else $error("holding register moved during shift");
    a_rdrf_read: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (rxh_rd && !q_pop && !mr) |=> !rdrf)
        else $error("receive full not cleared by read");
    a_break_line: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        txc == asr_pkg::ASR_TXC_BREAK |-> !tx_data_out && !rts_n_out)
        else $error("break or rts wrong");
    a_ovr_on_read: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (rxh_rd && ovr_pend && !mr) |=> ovr ##1 ovr || $past(rxh_rd) || mr)
        else $error("overrun not flagged on read");
endmodule // asr_top

`default_nettype wire

// *** verif/asr_peer.sv ***
`timescale 1ns/10ps
`default_nettype none

module asr_peer (
    output logic link_clk_out,
    output logic rx_data_out,
    input wire logic tx_data_in
);
    // one free running bit clock feeds both directions, so the ratios match
    initial link_clk_out = 1'b0;
    always #202.53 link_clk_out = ~link_clk_out;
    initial rx_data_out = 1'b1;

    task automatic put(input logic b, input int m);
        @(negedge link_clk_out) rx_data_out = b;
        repeat (m - 1) @(negedge link_clk_out);
    endtask

    // data changes on falling edges, lsb first; flaw[0] bad parity, flaw[1] low stop
    task automatic send(input logic [7:0] d, input logic [2:0] fmt, input int m, input logic [1:0] flaw);
        logic [7:0] w;
        w = fmt[2] ? d : {1'b0, d[6:0]};
        put(1'b0, m);
        for (int i = 0; i < (fmt[2] ? 8 : 7); i++) put(w[i], m);
        if (fmt[2:1] != 2'h2) put(^w ^ fmt[0] ^ flaw[0], m);
        put(~flaw[1], m);
        if (fmt inside {3'h0, 3'h1, 3'h4}) put(1'b1, m);
        put(1'b1, 2 * m);
    endtask

    // samples mid-bit on rising edges, eight data bits
    task automatic recv(input int m, output logic [7:0] d);
        d = 8'h00;
        @(posedge link_clk_out iff tx_data_in === 1'b0);
        repeat (m / 2) @(posedge link_clk_out);
        for (int i = 0; i < 8; i++) begin
            repeat (m) @(posedge link_clk_out);
            d[i] = tx_data_in;
        end
    endtask
endmodule // asr_peer

`default_nettype wire

// *** verif/asr_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module asr_top_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic e = 1'b0;
    logic [2:0] cs = 3'h0;
    logic rnw = 1'b1;
    logic reg_sel = 1'b0;
    logic [7:0] di = 8'h00;
    logic cts_n = 1'b0;
    logic dcd_n = 1'b0;
    logic [7:0] do_val;
    logic irq_n, link_clk, rx_data, tx_data, rts_n, rie;
    logic [7:0] rd, got;
    logic [7:0] w [6];
    logic [2:0] fmt;
    int mtab [3] = '{1, 16, 64};
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    asr_top i_asr_top (.sys_clk_in(sys_clk), .nrst_in(nrst), .bus_e_in(e), .cs_in(cs), .rnw_in(rnw),
        .register_select_in(reg_sel), .di_in(di), .do_out(do_val), .irq_n_out(irq_n), .rx_clk_in(link_clk),
        .rx_data_in(rx_data), .tx_clk_in(link_clk), .tx_data_out(tx_data), .rts_n_out(rts_n),
        .cts_n_in(cts_n), .dcd_n_in(dcd_n));
    asr_peer i_asr_peer (.link_clk_out(link_clk), .rx_data_out(rx_data), .tx_data_in(tx_data));

    always #12.5 sys_clk = ~sys_clk;

    // the divide-by-64 frames dominate; about 32k cycles expected
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] g, input logic [7:0] x, input logic [7:0] mask);
        check_count++;
        if ((g & mask) !== (x & mask)) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g & mask, x & mask);
        end
    endtask

    // enable stays high longer than one bit clock; selects held past the falling edge
    task automatic cycle(input logic r, input logic s, input logic [7:0] wd);
        cs <= asr_pkg::CS_MATCH;
        rnw <= r;
        reg_sel <= s;
        di <= wd;
        @(posedge sys_clk);
        e <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rd = do_val;
        e <= 1'b0;
        repeat (6) @(posedge sys_clk);
        cs <= 3'h0;
        @(posedge sys_clk);
    endtask

    function automatic logic [7:0] exp_data(input logic [7:0] d, input logic [2:0] f);
        return f[2] ? d : {1'b0, d[6:0]};
    endfunction

    function automatic logic [7:0] exp_stat(input logic [2:0] f, input logic [1:0] fl, input logic ie);
        return {ie, fl[0] & (f[2:1] != 2'h2), 1'b0, fl[1], 3'h0, 1'b1};
    endfunction

    initial begin
        void'($urandom(33057));
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h00, 8'hFF);
        check({7'h0, irq_n}, 8'h01, 8'hFF);
        for (int r = 0; r < 3; r++) begin
            w[0] = 8'($urandom);
            w[1] = 8'($urandom);
            cycle(1'b0, 1'b0, {3'h0, 3'h5, 2'(r)});
            i_asr_peer.send(w[0], 3'h5, mtab[r], 2'h0);
            cycle(1'b1, 1'b1, 8'h00);
            check(rd, w[0], 8'hFF);
            fork
                i_asr_peer.recv(mtab[r], got);
                cycle(1'b0, 1'b1, w[1]);
            join
            check(got, w[1], 8'hFF);
        end
        foreach (w[k]) w[k] = 8'($urandom);
        for (int f = 0; f < 8; f++) begin
            fmt = 3'(f);
            rie = 1'($urandom);
            cycle(1'b0, 1'b0, {rie, 2'h0, fmt, 2'h0});
            i_asr_peer.send(w[f % 6], fmt, 1, 2'(f % 4));
            check({7'h0, irq_n}, {7'h0, ~rie}, 8'h01);
            cycle(1'b1, 1'b0, 8'h00);
            check(rd, exp_stat(fmt, 2'(f % 4), rie), 8'hFD);
            cycle(1'b1, 1'b1, 8'h00);
            check(rd, exp_data(w[f % 6], fmt), 8'hFF);
            cycle(1'b1, 1'b0, 8'h00);
            check(rd, 8'h00, 8'hE1);
        end
        cycle(1'b0, 1'b0, 8'h94);
        for (int k = 0; k < 6; k++) i_asr_peer.send(w[k], 3'h5, 1, 2'h0);
        cycle(1'b1, 1'b1, 8'h00);
        check(rd, w[0], 8'hFF);
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'hA1, 8'hE1);
        cycle(1'b1, 1'b1, 8'h00);
        check(rd, w[1], 8'hFF);
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h81, 8'hE1);
        dcd_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        dcd_n <= 1'b0;
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h04, 8'h04);
        cycle(1'b1, 1'b1, 8'h00);
        cycle(1'b1, 1'b0, 8'h00);
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h00, 8'h04);
        cycle(1'b0, 1'b0, 8'h97);
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h00, 8'hFF);
        cycle(1'b0, 1'b0, 8'h14);
        fork
            begin
                i_asr_peer.recv(1, got);
                check(got, w[2], 8'hFF);
                i_asr_peer.recv(1, got);
                check(got, w[3], 8'hFF);
            end
            begin
                cycle(1'b0, 1'b1, w[2]);
                cycle(1'b0, 1'b1, w[3]);
            end
        join
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h02, 8'h0A);
        cts_n <= 1'b1;
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h08, 8'h0A);
        cts_n <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            cycle(1'b0, 1'b0, {1'b0, 2'(c), 3'h5, 2'h0});
            cycle(1'b1, 1'b0, 8'h00);
            check({4'h0, rd[7], irq_n, rts_n, tx_data}, {4'h0, c == 1, c != 1, c == 2, c != 3}, 8'h0F);
        end
        // mid-run reset just after a bit clock rise: the cts bit must hold high until the next rise
        @(posedge link_clk);
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(posedge sys_clk);
        nrst <= 1'b1;
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h08, 8'hFF);
        cycle(1'b1, 1'b0, 8'h00);
        check(rd, 8'h00, 8'hFF);
        conclude();
    end
endmodule // asr_top_tb

`default_nettype wire
